//--- pkg/edge_shaper_pkg.sv
package edge_shaper_pkg;
    // register indices (offsets not multiples of four, byte address = 4 * index)
    localparam logic [7:0] idx_style = 8'h39;
    localparam logic [7:0] idx_param = 8'h3a;
    localparam logic [7:0] idx_length = 8'h3b;
    localparam logic [7:0] idx_residual = 8'h4c;
    localparam logic [7:0] idx_status = 8'h4d;
    localparam logic [9:0] addr_style = 10'h0e4;
    localparam logic [9:0] addr_param = 10'h0e8;
    localparam logic [9:0] addr_length = 10'h0ec;
    localparam logic [9:0] addr_residual = 10'h130;
    localparam logic [9:0] addr_status = 10'h134;
    // reset values
    localparam logic [7:0] style_rst = 8'h11;
    localparam logic [7:0] param_rst = 8'h00;
    localparam logic [7:0] length_rst = 8'h00;
    localparam logic [7:0] residual_rst = 8'hff;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] param_mask = 8'h77;
    localparam logic [7:0] length_mask = 8'h9f;
    // field positions
    localparam int fall_style_lsb = 4;
    localparam int double_bit = 7;
    // style codes
    localparam logic [3:0] style_fw_one = 4'h1;
    localparam logic [3:0] style_fw_three = 4'h3;
    localparam logic [3:0] style_lut_plain = 4'h4;
    localparam logic [3:0] style_lut_corr = 4'h5;
    localparam logic [3:0] style_lut_nocorr = 4'h6;
    localparam logic [1:0] unmapped_resp = 2'b10;

    typedef struct packed {
        logic valid;
        logic lut_mode;
        logic supply_adapt;
        logic supply_correct;
        logic [1:0] ramp_count;
        logic [2:0] cfg;
    } edge_cfg_t;

    typedef struct packed {
        logic [4:0] states;
        logic double_len;
        logic [7:0] residual_level;
    } shape_timing_t;
endpackage

//--- design/edge_shaper_cfg.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
// Functional notes
// - Falling style codes 1..3 in bits 7:4 select firmware shaping with one, two or three linear ramps.
// - Style codes 4..6 select lookup-table shaping: plain, supply adaptation with correction, without correction.
// - Bits 3:0 select the rising style from the same codes; other codes are reserved and not to be programmed.
// - Under firmware shaping the falling configuration bits 6:4 are the edge time constant.
// - Under lookup-table shaping the falling configuration selects lookup table 0..3.
// - Rising configuration bits 2:0 mean a time constant or a table index 0..3 in the same way.
// - Length bit 7 makes each transition state last two carrier cycles instead of one.
// - Length bits 4:0 give the number of transition states on both edges.
// - The vicinity residual level 0x00 means no carrier and 0xff full carrier during modulation.
module edge_shaper_cfg (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // avalon-mm slave
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    // shaper configuration to the transmitter
    output edge_shaper_pkg::edge_cfg_t fall_cfg_o,
    output edge_shaper_pkg::edge_cfg_t rise_cfg_o,
    output edge_shaper_pkg::shape_timing_t timing_o
);
    logic [7:0] style_r;
    logic [7:0] param_r;
    logic [7:0] length_r;
    logic [7:0] residual_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [1:0] resp_r;
    edge_shaper_pkg::edge_cfg_t fall_r;
    edge_shaper_pkg::edge_cfg_t rise_r;
    edge_shaper_pkg::shape_timing_t timing_r;

    wire req = (avs_read_i | avs_write_i) & ~ack_r;
    // a write lands at the edge where waitrequest is low
    wire wr_en = avs_write_i & ack_r & avs_byteenable_i[0];
    wire sel_style = avs_address_i == edge_shaper_pkg::addr_style;
    wire sel_param = avs_address_i == edge_shaper_pkg::addr_param;
    wire sel_length = avs_address_i == edge_shaper_pkg::addr_length;
    wire sel_residual = avs_address_i == edge_shaper_pkg::addr_residual;
    wire sel_status = avs_address_i == edge_shaper_pkg::addr_status;
    wire mapped = sel_style | sel_param | sel_length | sel_residual | sel_status;
    wire [7:0] wbyte = avs_writedata_i[7:0];

    wire [7:0] status_val = {6'h00, ~rise_r.valid, ~fall_r.valid};
    logic [7:0] rsel;
    always_comb begin
        if (sel_style) begin
            rsel = style_r;
        end else if (sel_param) begin
            rsel = param_r;
        end else if (sel_length) begin
            rsel = length_r;
        end else if (sel_residual) begin
            rsel = residual_r;
        end else if (sel_status) begin
            rsel = status_val;
        end else begin
            rsel = 8'h00;
        end
    end

    function automatic edge_shaper_pkg::edge_cfg_t decode(input logic [3:0] code, input logic [2:0] cfg);
        edge_shaper_pkg::edge_cfg_t d;
        d = '0;
        d.cfg = cfg;
        if (code >= edge_shaper_pkg::style_fw_one && code <= edge_shaper_pkg::style_fw_three) begin
            d.valid = 1'b1;
            d.ramp_count = code[1:0];
            d.cfg = cfg;
        end else if (code >= edge_shaper_pkg::style_lut_plain && code <= edge_shaper_pkg::style_lut_nocorr) begin
            d.valid = 1'b1;
            d.lut_mode = 1'b1;
            d.supply_adapt = code != edge_shaper_pkg::style_lut_plain;
            d.supply_correct = code == edge_shaper_pkg::style_lut_corr;
            d.cfg = {1'b0, cfg[1:0]};
        end else begin
            d.cfg = 3'h0;
        end
        return d;
    endfunction

    wire [7:0] pm = param_r & edge_shaper_pkg::param_mask;
    wire edge_shaper_pkg::edge_cfg_t fall_nxt =
        decode(style_r[edge_shaper_pkg::fall_style_lsb +: 4], pm[6:4]);
    wire edge_shaper_pkg::edge_cfg_t rise_nxt = decode(style_r[3:0], pm[2:0]);
    wire edge_shaper_pkg::shape_timing_t timing_nxt =
        {length_r[4:0], length_r[edge_shaper_pkg::double_bit], residual_r};

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            style_r <= edge_shaper_pkg::style_rst;
            param_r <= edge_shaper_pkg::param_rst;
            length_r <= edge_shaper_pkg::length_rst;
            residual_r <= edge_shaper_pkg::residual_rst;
        end else if (wr_en) begin
            if (sel_style) begin
                style_r <= wbyte;
            end
            if (sel_param) begin
                param_r <= wbyte & edge_shaper_pkg::param_mask;
            end
            if (sel_length) begin
                length_r <= wbyte & edge_shaper_pkg::length_mask;
            end
            if (sel_residual) begin
                residual_r <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            resp_r <= 2'b00;
        end else begin
            ack_r <= req;
            rdata_r <= {24'h00_0000, rsel};
            resp_r <= mapped ? 2'b00 : edge_shaper_pkg::unmapped_resp;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fall_r <= '0;
            rise_r <= '0;
            timing_r <= '0;
        end else begin
            fall_r <= fall_nxt;
            rise_r <= rise_nxt;
            timing_r <= timing_nxt;
        end
    end

    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = ~ack_r;
    assign avs_response_o = resp_r;
    assign fall_cfg_o = fall_r;
    assign rise_cfg_o = rise_r;
    assign timing_o = timing_r;
endmodule

//--- dv/tx_sink_model.sv
`timescale 1ns/1ns
module tx_sink_model (
    // clock
    input wire logic clk_i,
    // settings from the shaper
    input wire edge_shaper_pkg::shape_timing_t timing_i,
    // carrier cycles one edge lasts
    output logic [5:0] edge_cycles_o
);
    always_ff @(posedge clk_i) begin
        edge_cycles_o <= timing_i.double_len ? {timing_i.states, 1'b0} : {1'b0, timing_i.states};
    end
endmodule

//--- dv/edge_shaper_cfg_assertions.sv
`timescale 1ns/1ns
module edge_shaper_cfg_assertions (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire edge_shaper_pkg::edge_cfg_t fall_cfg_o,
    input wire edge_shaper_pkg::edge_cfg_t rise_cfg_o,
    input wire edge_shaper_pkg::shape_timing_t timing_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire wa = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire [9:0] a = avs_address_i;
    chk_style_fall: assert property (wa && a == edge_shaper_pkg::addr_style |-> ##2
        fall_cfg_o.valid == ($past(avs_writedata_i[7:4], 2) inside {[4'h1:4'h6]})) else $error("fall valid");
    chk_style_rise: assert property (wa && a == edge_shaper_pkg::addr_style |-> ##2
        rise_cfg_o.valid == ($past(avs_writedata_i[3:0], 2) inside {[4'h1:4'h6]})) else $error("rise valid");
    chk_length_set: assert property (wa && a == edge_shaper_pkg::addr_length |-> ##2
        {timing_o.double_len, timing_o.states} == $past({avs_writedata_i[7], avs_writedata_i[4:0]}, 2))
        else $error("length");
    chk_residual_set: assert property (wa && a == edge_shaper_pkg::addr_residual |-> ##2
        timing_o.residual_level == $past(avs_writedata_i[7:0], 2)) else $error("residual");
    chk_param_rsvd: assert property (avs_read_i && !avs_waitrequest_o && a == edge_shaper_pkg::addr_param
        |-> (avs_readdata_o & 32'hffffff88) == 32'h0) else $error("param reserved bits");
    chk_adapt_lut: assert property (fall_cfg_o.supply_correct |-> fall_cfg_o.supply_adapt && fall_cfg_o.lut_mode)
        else $error("correction without adaptation");
    chk_fw_ramps: assert property (fall_cfg_o.valid && !fall_cfg_o.lut_mode |-> fall_cfg_o.ramp_count != 2'h0)
        else $error("no ramps");
    chk_rsvd_zero: assert property (!rise_cfg_o.valid |-> rise_cfg_o.cfg == 3'h0) else $error("reserved cfg");
    cover property (fall_cfg_o.lut_mode);
    cover property (timing_o.double_len);
    cover property (!rise_cfg_o.valid);
endmodule
bind edge_shaper_cfg edge_shaper_cfg_assertions edge_shaper_cfg_assertions_inst (.clk_i(clk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .fall_cfg_o(fall_cfg_o), .rise_cfg_o(rise_cfg_o), .timing_o(timing_o));

//--- dv/test_edge_shaper_cfg.sv
`timescale 1ns/1ns
module test_edge_shaper_cfg;
    logic clk_i = 0;
    logic srst_i = 1;
    logic [9:0] adr = 0;
    logic rd = 0;
    logic we = 0;
    logic [31:0] wd = 0;
    logic [3:0] be = 0;
    logic [31:0] rdat;
    logic wait_o;
    logic [1:0] resp;
    edge_shaper_pkg::edge_cfg_t fall;
    edge_shaper_pkg::edge_cfg_t rise;
    edge_shaper_pkg::shape_timing_t tim;
    logic [5:0] cyc;
    int fail_count = 0;
    int n_tests = 0;
    int tick = 0;
    edge_shaper_cfg edge_shaper_cfg_inst (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(we), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_o), .avs_response_o(resp), .fall_cfg_o(fall), .rise_cfg_o(rise), .timing_o(tim));
    tx_sink_model tx_sink_model_inst (.clk_i(clk_i), .timing_i(tim), .edge_cycles_o(cyc));
    initial forever #20 clk_i = ~clk_i;
    task summarize;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        tick++;
        if (tick == 2000) begin
            fail_count++;
            summarize;
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] b);
        adr <= a;
        wd <= {24'h0, d};
        be <= b;
        we <= 1'b1;
        do @(posedge clk_i); while (wait_o !== 1'b0);
        we <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task rdc(input logic [9:0] a, input logic [7:0] e, input logic [1:0] r);
        adr <= a;
        rd <= 1'b1;
        do @(posedge clk_i); while (wait_o !== 1'b0);
        chk("readdata", {24'h0, e}, rdat);
        chk("response", {30'h0, r}, {30'h0, resp});
        rd <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        logic v;
        logic l;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        rdc(edge_shaper_pkg::addr_style, 8'h11, 2'b00);
        rdc(edge_shaper_pkg::addr_residual, 8'hff, 2'b00);
        wr(edge_shaper_pkg::addr_param, 8'hff, 4'h1);
        rdc(edge_shaper_pkg::addr_param, 8'h77, 2'b00);
        wr(edge_shaper_pkg::addr_param, 8'h37, 4'h1);
        for (int c = 0; c < 16; c++) begin
            v = c inside {[1:6]};
            l = v && c > 3;
            wr(edge_shaper_pkg::addr_style, {c[3:0], c[3:0]}, 4'h1);
            chk("fall", {v, l, v && c > 4, c == 5, v ? 3'h3 : 3'h0}, {fall[8:5], fall.cfg});
            chk("rise", {v, l, v && c > 4, c == 5, v ? (l ? 3'h3 : 3'h7) : 3'h0}, {rise[8:5], rise.cfg});
            if (v && !l) chk("rise ramps", 32'(c), {30'h0, rise.ramp_count});
            if (v && !l) chk("ramps", 32'(c), {30'h0, fall.ramp_count});
            rdc(edge_shaper_pkg::addr_status, v ? 8'h00 : 8'h03, 2'b00);
        end
        wr(edge_shaper_pkg::addr_length, 8'hff, 4'h1);
        chk("cycles", 32'd62, {26'h0, cyc});
        wr(edge_shaper_pkg::addr_length, 8'h05, 4'h0);
        rdc(edge_shaper_pkg::addr_length, 8'h9f, 2'b00);
        wr(edge_shaper_pkg::addr_length, 8'h05, 4'h1);
        chk("cycles", 32'd5, {26'h0, cyc});
        wr(edge_shaper_pkg::addr_residual, 8'h00, 4'h1);
        chk("level", 32'h0, {24'h0, tim.residual_level});
        wr(10'h3fc, 8'h5a, 4'h1);
        rdc(10'h3fc, 8'h00, 2'b10);
        summarize;
    end
endmodule
